// ==== ptm_pkg.sv ====
// Constants for the 10-bit periodic timer: register map, field layout, codes.
// Assumes a byte-wide register port with a 3-bit word index.
package ptm_pkg;

    localparam int ADDR_W = 3;
    localparam int DATA_W = 8;
    localparam int CNT_W = 10;

    // Register indices.
    localparam logic [2:0] ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] ADDR_CMPA_LO = 3'h4;
    localparam logic [2:0] ADDR_CMPA_HI = 3'h5;
    localparam logic [2:0] ADDR_PER_LO = 3'h6;
    localparam logic [2:0] ADDR_PER_HI = 3'h7;

    // Control zero fields.
    localparam int C0_PAUSE = 7;
    localparam int C0_CKSEL_LSB = 4;
    localparam int C0_RUN = 3;
    localparam logic [7:0] C0_WMASK = 8'hf8;

    // Control one fields.
    localparam int C1_MODE_LSB = 6;
    localparam int C1_IO_LSB = 4;
    localparam int C1_OC = 3;
    localparam int C1_POL = 2;
    localparam int C1_CAPTS = 1;
    localparam int C1_CCLR = 0;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [9:0] CNT_RESET = 10'h000;
    localparam logic [9:0] CNT_MAX = 10'h3ff;
    localparam logic [9:0] CNT_ONE = 10'h001;
    localparam logic [5:0] HI_PAD = 6'h00;

    // Operating modes.
    localparam logic [1:0] MODE_CMP = 2'h0;
    localparam logic [1:0] MODE_CAP = 2'h1;
    localparam logic [1:0] MODE_PWM = 2'h2;
    localparam logic [1:0] MODE_TMR = 2'h3;

    // Pin function codes, per mode.
    localparam logic [1:0] IO_CMP_LOW = 2'h1;
    localparam logic [1:0] IO_CMP_HIGH = 2'h2;
    localparam logic [1:0] IO_CMP_TOG = 2'h3;
    localparam logic [1:0] IO_PWM_INACT = 2'h0;
    localparam logic [1:0] IO_PWM_ACT = 2'h1;
    localparam logic [1:0] IO_PWM_OUT = 2'h2;
    localparam logic [1:0] IO_SPULSE = 2'h3;
    localparam logic [1:0] IO_CAP_RISE = 2'h0;
    localparam logic [1:0] IO_CAP_FALL = 2'h1;
    localparam logic [1:0] IO_CAP_BOTH = 2'h2;

    // Clock source codes.
    localparam logic [2:0] CK_SYS4 = 3'h0;
    localparam logic [2:0] CK_SYS = 3'h1;
    localparam logic [2:0] CK_H16 = 3'h2;
    localparam logic [2:0] CK_H64 = 3'h3;
    localparam logic [2:0] CK_SUB0 = 3'h4;
    localparam logic [2:0] CK_SUB1 = 3'h5;
    localparam logic [2:0] CK_EXT_RISE = 3'h6;
    localparam logic [2:0] CK_EXT_FALL = 3'h7;

    // Prescaler terminal counts.
    localparam logic [1:0] SYS4_LAST = 2'h3;
    localparam logic [1:0] SYS4_ONE = 2'h1;
    localparam logic [3:0] H16_LAST = 4'hf;
    localparam logic [5:0] H64_LAST = 6'h3f;
    localparam logic [5:0] HDIV_ONE = 6'h01;

endpackage

// ==== ptm_top.sv ====
// Periodic timer: 10-bit up counter, two comparators, four modes.
// Assumes all pins synchronous to mclk; high and sub clocks arrive as
// one-cycle tick enables.
//
// Overview of operation
// R1 - Three-bit field picks the counter clock source.
// R2 - Run bit rising clears the counter.
// R3 - Run bit low stops and holds count.
// R4 - Run rising restores initial output level. The code does so only outside capture and timer modes.
// R5 - Two-bit field selects the operating mode.
// R6 - Software turns off before changing mode.
// R7 - Timer mode leaves the output pin unused.
// R8 - Compare match A: none, low, high, toggle.
// R9 - PWM modes: inactive, active, PWM, single pulse.
// R10 - Capture on rising, falling, both, or off.
// R11 - Requested level equal initial shows no change.
// R12 - Software changes pin function only when off.
// R13 - Output-control bit sets initial or active level.
// R14 - Polarity bit inverts the output pin.
// R15 - Capture source: capture pin or clock pin.
// R16 - Clear on A match, or P/overflow.
// R17 - Clear-select ignored outside compare and timer modes.
// R18 - Counter readable as low and high bytes.
// R19 - Compare A and period are read/write pairs.
// R20 - Clear-select zero raises both A and P flags.
// R21 - Clear-select one never raises P flag.
// R22 - Zero compare A overflows without A flag.
// R23 - Pause holds the counter, resumes after.
// R24 - Only A match changes compare-mode output.
// R25 - Counter increments on each selected clock edge.
//
// Added by the designer: the register offsets and the strobed register port.
`timescale 1ns/1ps
`default_nettype none

module ptm_top (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata_q,
    input wire logic high_clk_tick,
    input wire logic sub_clk_tick,
    input wire logic external_clock_pin,
    input wire logic capture_input_pin,
    output logic timer_output_pin_q,
    output logic timer_output_en_q,
    output logic compare_a_flag_q,
    output logic compare_p_flag_q
);

    ////////////////////////////////////////////////////////////////////////////
    // State.

    logic [7:0] c0_q, c0_d, c1_q, c1_d, reg_rdata_d;
    logic [9:0] cnt_q, cnt_d, cmpa_q, cmpa_d, per_q, per_d, cnt_inc;
    logic run_prev_q, ext_prev_q, capin_prev_q, out_raw_q, out_raw_d;
    logic pin_d, pin_en_d;
    logic [1:0] sys_div_q, sys_div_d;
    logic [5:0] h_div_q, h_div_d;
    logic fa_ev, fp_ev, cap_ev, cnt_tick;

    logic run_q, pause_q, run_rise, oc, cclr, sp_mode;
    logic [2:0] cksel;
    logic [1:0] mode, io;
    logic ext_rise, ext_fall, cap_src, cap_prev, a_eq, p_hit, ovf;

    assign run_q = c0_q[ptm_pkg::C0_RUN];
    assign pause_q = c0_q[ptm_pkg::C0_PAUSE];
    assign cksel = c0_q[ptm_pkg::C0_CKSEL_LSB +: 3];
    assign mode = c1_q[ptm_pkg::C1_MODE_LSB +: 2];
    assign io = c1_q[ptm_pkg::C1_IO_LSB +: 2];
    assign oc = c1_q[ptm_pkg::C1_OC];
    assign cclr = c1_q[ptm_pkg::C1_CCLR];
    assign sp_mode = (mode == ptm_pkg::MODE_PWM) && (io == ptm_pkg::IO_SPULSE);
    assign run_rise = run_q && !run_prev_q;
    assign cnt_inc = cnt_q + ptm_pkg::CNT_ONE;
    assign ext_rise = external_clock_pin && !ext_prev_q;
    assign ext_fall = !external_clock_pin && ext_prev_q;
    assign a_eq = (cnt_q == cmpa_q);
    // A zero period lets the counter run to its maximum and wrap.
    assign p_hit = (per_q != ptm_pkg::CNT_RESET) && (cnt_q == per_q);
    assign ovf = (per_q == ptm_pkg::CNT_RESET) && (cnt_q == ptm_pkg::CNT_MAX);

    ////////////////////////////////////////////////////////////////////////////
    // Clock selection and capture edge detection.

    always_comb begin
        sys_div_d = sys_div_q + ptm_pkg::SYS4_ONE;
        h_div_d = h_div_q;
        if (high_clk_tick) begin
            h_div_d = h_div_q + ptm_pkg::HDIV_ONE;
        end
        case (cksel) // R1
            ptm_pkg::CK_SYS4: cnt_tick = (sys_div_q == ptm_pkg::SYS4_LAST);
            ptm_pkg::CK_SYS: cnt_tick = 1'b1;
            ptm_pkg::CK_H16: cnt_tick = high_clk_tick && (h_div_q[3:0] == ptm_pkg::H16_LAST);
            ptm_pkg::CK_H64: cnt_tick = high_clk_tick && (h_div_q == ptm_pkg::H64_LAST);
            ptm_pkg::CK_SUB0, ptm_pkg::CK_SUB1: cnt_tick = sub_clk_tick;
            ptm_pkg::CK_EXT_RISE: cnt_tick = ext_rise;
            ptm_pkg::CK_EXT_FALL: cnt_tick = ext_fall;
            default: cnt_tick = 1'b0;
        endcase
        cap_src = c1_q[ptm_pkg::C1_CAPTS] ? external_clock_pin : capture_input_pin; // R15
        cap_prev = c1_q[ptm_pkg::C1_CAPTS] ? ext_prev_q : capin_prev_q;
        case (io) // R10
            ptm_pkg::IO_CAP_RISE: cap_ev = cap_src && !cap_prev;
            ptm_pkg::IO_CAP_FALL: cap_ev = !cap_src && cap_prev;
            ptm_pkg::IO_CAP_BOTH: cap_ev = cap_src != cap_prev;
            default: cap_ev = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Counter, comparators, output level and register writes.

    always_comb begin
        c0_d = c0_q;
        c1_d = c1_q;
        cnt_d = cnt_q;
        cmpa_d = cmpa_q;
        per_d = per_q;
        out_raw_d = out_raw_q;
        fa_ev = 1'b0;
        fp_ev = 1'b0;
        if (run_rise) begin
            cnt_d = ptm_pkg::CNT_RESET; // R2
            if (mode != ptm_pkg::MODE_CAP && mode != ptm_pkg::MODE_TMR) begin
                out_raw_d = oc; // R4 R13
            end
        end else if (run_q && !pause_q && cnt_tick) begin // R3 R23
            cnt_d = cnt_inc; // R25
            case (mode) // R5
                ptm_pkg::MODE_CMP, ptm_pkg::MODE_TMR: begin
                    if (cclr) begin
                        // A zero compare value never matches, so the count wraps.
                        if (a_eq && cmpa_q != ptm_pkg::CNT_RESET) begin // R16 R21 R22
                            fa_ev = 1'b1;
                            cnt_d = ptm_pkg::CNT_RESET;
                        end
                    end else begin
                        fa_ev = a_eq && (cmpa_q != ptm_pkg::CNT_RESET); // R20 R22
                        if (p_hit || ovf) begin // R16 R20
                            fp_ev = 1'b1;
                            cnt_d = ptm_pkg::CNT_RESET;
                        end
                    end
                    if (mode == ptm_pkg::MODE_CMP && fa_ev) begin // R24
                        case (io) // R8 R11
                            ptm_pkg::IO_CMP_LOW: out_raw_d = 1'b0;
                            ptm_pkg::IO_CMP_HIGH: out_raw_d = 1'b1;
                            ptm_pkg::IO_CMP_TOG: out_raw_d = !out_raw_q;
                            default: out_raw_d = out_raw_q;
                        endcase
                    end
                end
                ptm_pkg::MODE_PWM: begin
                    if (sp_mode) begin
                        if (a_eq) begin
                            fa_ev = 1'b1;
                            out_raw_d = !oc; // R9
                            c0_d[ptm_pkg::C0_RUN] = 1'b0;
                        end
                    end else begin
                        fa_ev = a_eq; // R17
                        if (p_hit || ovf) begin
                            fp_ev = 1'b1;
                            cnt_d = ptm_pkg::CNT_RESET;
                        end
                    end
                end
                default: begin
                    if (p_hit || ovf) begin // R17
                        fp_ev = 1'b1;
                        cnt_d = ptm_pkg::CNT_RESET;
                    end
                end
            endcase
        end
        // Waveform level follows the count continuously in PWM output.
        if (run_q && !run_rise && mode == ptm_pkg::MODE_PWM && !sp_mode) begin
            case (io) // R9 R13
                ptm_pkg::IO_PWM_INACT: out_raw_d = !oc;
                ptm_pkg::IO_PWM_ACT: out_raw_d = oc;
                ptm_pkg::IO_PWM_OUT: begin
                    if (cnt_q < cmpa_q || (per_q != ptm_pkg::CNT_RESET && cmpa_q >= per_q)) begin
                        out_raw_d = oc;
                    end else begin
                        out_raw_d = !oc;
                    end
                end
                default: out_raw_d = out_raw_q;
            endcase
        end
        if (sp_mode && !run_q && ext_rise) begin
            c0_d[ptm_pkg::C0_RUN] = 1'b1;
        end
        // Software writes come after the hardware run clear, so a set wins.
        if (reg_wr) begin
            case (reg_addr)
                ptm_pkg::ADDR_CTRL0: c0_d = reg_wdata & ptm_pkg::C0_WMASK;
                ptm_pkg::ADDR_CTRL1: c1_d = reg_wdata;
                ptm_pkg::ADDR_CMPA_LO: cmpa_d[7:0] = reg_wdata; // R19
                ptm_pkg::ADDR_CMPA_HI: cmpa_d[9:8] = reg_wdata[1:0];
                ptm_pkg::ADDR_PER_LO: per_d[7:0] = reg_wdata;
                ptm_pkg::ADDR_PER_HI: per_d[9:8] = reg_wdata[1:0];
                default: c0_d = c0_d;
            endcase
        end
        // A capture overrides a software write of compare A in the same cycle.
        if (mode == ptm_pkg::MODE_CAP && run_q && !run_rise && cap_ev) begin // R10
            cmpa_d = cnt_q;
            fa_ev = 1'b1;
        end
        pin_en_d = (c1_d[ptm_pkg::C1_MODE_LSB +: 2] != ptm_pkg::MODE_TMR); // R7
        pin_d = pin_en_d && (out_raw_d ^ c1_d[ptm_pkg::C1_POL]); // R14
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read port.

    always_comb begin
        reg_rdata_d = ptm_pkg::REG_RESET;
        if (reg_rd) begin
            case (reg_addr) // R18 R19
                ptm_pkg::ADDR_CTRL0: reg_rdata_d = c0_q;
                ptm_pkg::ADDR_CTRL1: reg_rdata_d = c1_q;
                ptm_pkg::ADDR_CNT_LO: reg_rdata_d = cnt_q[7:0];
                ptm_pkg::ADDR_CNT_HI: reg_rdata_d = {ptm_pkg::HI_PAD, cnt_q[9:8]};
                ptm_pkg::ADDR_CMPA_LO: reg_rdata_d = cmpa_q[7:0];
                ptm_pkg::ADDR_CMPA_HI: reg_rdata_d = {ptm_pkg::HI_PAD, cmpa_q[9:8]};
                ptm_pkg::ADDR_PER_LO: reg_rdata_d = per_q[7:0];
                ptm_pkg::ADDR_PER_HI: reg_rdata_d = {ptm_pkg::HI_PAD, per_q[9:8]};
                default: reg_rdata_d = ptm_pkg::REG_RESET;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            c0_q <= ptm_pkg::REG_RESET;
            c1_q <= ptm_pkg::REG_RESET;
            cnt_q <= ptm_pkg::CNT_RESET;
            cmpa_q <= ptm_pkg::CNT_RESET;
            per_q <= ptm_pkg::CNT_RESET;
            run_prev_q <= 1'b0;
            ext_prev_q <= 1'b0;
            capin_prev_q <= 1'b0;
            out_raw_q <= 1'b0;
            sys_div_q <= 2'h0;
            h_div_q <= 6'h00;
            reg_rdata_q <= ptm_pkg::REG_RESET;
            timer_output_pin_q <= 1'b0;
            timer_output_en_q <= 1'b0;
            compare_a_flag_q <= 1'b0;
            compare_p_flag_q <= 1'b0;
        end else begin
            c0_q <= c0_d;
            c1_q <= c1_d;
            cnt_q <= cnt_d;
            cmpa_q <= cmpa_d;
            per_q <= per_d;
            run_prev_q <= run_q;
            ext_prev_q <= external_clock_pin;
            capin_prev_q <= capture_input_pin;
            out_raw_q <= out_raw_d;
            sys_div_q <= sys_div_d;
            h_div_q <= h_div_d;
            reg_rdata_q <= reg_rdata_d;
            timer_output_pin_q <= pin_d;
            timer_output_en_q <= pin_en_d;
            compare_a_flag_q <= fa_ev;
            compare_p_flag_q <= fp_ev;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks.

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    AST_RUN_RISE_CLEARS: assert property (run_rise |=> cnt_q == ptm_pkg::CNT_RESET) // R2
        else $error("counter not cleared after run rising");
    AST_OFF_HOLDS: assert property (!run_q |=> $stable(cnt_q)) // R3
        else $error("counter moved while off");
    AST_PAUSE_HOLDS: assert property (run_q && pause_q && !run_rise |=> $stable(cnt_q)) // R23
        else $error("counter moved while paused");
    AST_TICK_INCS: assert property (run_q && !pause_q && !run_rise && cnt_tick && !fp_ev
        && !(cclr && fa_ev && mode != ptm_pkg::MODE_PWM)
        |=> cnt_q == $past(cnt_inc)) // R25
        else $error("counter did not increment on tick");
    AST_INIT_LEVEL: assert property (run_rise && mode != ptm_pkg::MODE_CAP
        && mode != ptm_pkg::MODE_TMR |=> out_raw_q == $past(oc)) // R4
        else $error("output not at initial level after run rising");
    AST_NO_PF_CCLR: assert property (cclr && mode == ptm_pkg::MODE_CMP |=> !compare_p_flag_q) // R21
        else $error("P flag raised with clear on A");
    AST_ZERO_A: assert property (mode == ptm_pkg::MODE_CMP && cmpa_q == ptm_pkg::CNT_RESET
        |=> !compare_a_flag_q) // R22
        else $error("A flag raised with zero compare value");
    AST_TIMER_NO_PIN: assert property (mode == ptm_pkg::MODE_TMR && !reg_wr
        |=> !timer_output_en_q && !timer_output_pin_q) // R7
        else $error("output driven in timer mode");
    AST_TOGGLE: assert property (mode == ptm_pkg::MODE_CMP && io == ptm_pkg::IO_CMP_TOG && fa_ev
        && !reg_wr ##1 1 |=> 1'b1 ##0 (timer_output_pin_q != $past(timer_output_pin_q, 2))) // R8
        else $error("toggle did not change output");
    AST_CAPTURE: assert property (mode == ptm_pkg::MODE_CAP && run_q && !run_rise && cap_ev
        |=> cmpa_q == $past(cnt_q) && compare_a_flag_q) // R10
        else $error("capture did not latch counter");
    AST_SP_END: assert property (sp_mode && run_q && !run_rise && !pause_q && cnt_tick && a_eq
        && !reg_wr |=> !run_q && out_raw_q == !oc) // R9
        else $error("single pulse did not end on A match");

    COV_CAPTURE: cover property (mode == ptm_pkg::MODE_CAP && run_q && cap_ev);
    COV_SP_END: cover property (sp_mode && run_q ##1 !run_q);
    COV_PWM_PERIOD: cover property (mode == ptm_pkg::MODE_PWM && fp_ev);
    COV_OVERFLOW: cover property (run_q && cnt_tick && ovf);

endmodule

`default_nettype wire

// ==== ptm_pins_model.sv ====
// Far-side model: external clock pin, capture pin and internal clock ticks.
// Assumes the bench calls its tasks; every change follows a rising mclk edge.
`timescale 1ns/1ps
`default_nettype none
module ptm_pins_model (
    input wire logic mclk,
    output logic ext_clk,
    output logic cap_in,
    output logic high_tick,
    output logic sub_tick
);
    logic [3:0] div_q = 4'h0;
    initial begin
        ext_clk = 1'b0;
        cap_in = 1'b0;
    end
    // High ticks come every second cycle and sub ticks every third.
    always @(posedge mclk) begin
        div_q <= (div_q == 4'h5) ? 4'h0 : div_q + 4'h1;
        high_tick <= div_q[0];
        sub_tick <= (div_q == 4'h2) || (div_q == 4'h5);
    end
    task automatic ext_pulses(input int n);
        repeat (n) begin
            @(posedge mclk);
            ext_clk <= 1'b1;
            repeat (2) @(posedge mclk);
            ext_clk <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
    task automatic cap_set(input logic lvl);
        @(posedge mclk);
        cap_in <= lvl;
        repeat (3) @(posedge mclk);
    endtask
endmodule
`default_nettype wire

// ==== tb.sv ====
// Bench for the periodic timer: register tasks, mode scenarios, flag monitor.
// Assumes ptm_pkg, ptm_top and ptm_pins_model are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic mclk, rst_n, reg_wr, reg_rd, pin, en, a_flag, p_flag, pin_prev;
    logic ext_clk, cap_in, high_tick, sub_tick;
    logic [2:0] reg_addr;
    logic [7:0] reg_wdata, rdata, v, w;
    int n_fail, samples_checked, cyc, n_a, n_p, n_tog, a_gap, p_gap, a_last, p_last;
    int ba, bp, bt;
    int fac [6] = '{4, 1, 32, 128, 3, 3};
    int capn [4] = '{1, 1, 2, 0};
    ptm_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(rdata), .high_clk_tick(high_tick),
        .sub_clk_tick(sub_tick), .external_clock_pin(ext_clk), .capture_input_pin(cap_in),
        .timer_output_pin_q(pin), .timer_output_en_q(en), .compare_a_flag_q(a_flag),
        .compare_p_flag_q(p_flag));
    ptm_pins_model pins (.mclk(mclk), .ext_clk(ext_clk), .cap_in(cap_in),
        .high_tick(high_tick), .sub_tick(sub_tick));
    always #5 mclk = ~mclk;
    ////////////////////////////////////////////////////////////////
    // Flag and pin monitor: event counts and spacing in cycles.
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        pin_prev <= pin;
        if (pin_prev !== pin) begin
            n_tog <= n_tog + 1;
        end
        if (a_flag === 1'b1) begin
            n_a <= n_a + 1;
            a_gap <= cyc - a_last;
            a_last <= cyc;
        end
        if (p_flag === 1'b1) begin
            n_p <= n_p + 1;
            p_gap <= cyc - p_last;
            p_last <= cyc;
        end
    end
    task automatic print_verdict();
        $display("checks %0d errors %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        samples_checked++;
        if (g !== e) begin
            n_fail++;
            $display("ERROR %s expected %0h seen %0h", nm, e, g);
        end
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        #1 d = rdata;
    endtask
    // Switches the block off before mode or pin function change.
    task automatic cfg(input logic [7:0] c1, input logic [9:0] a, input logic [9:0] p);
        wr(3'h0, 8'h00);
        wr(3'h1, c1);
        wr(3'h4, a[7:0]);
        wr(3'h5, {6'h00, a[9:8]});
        wr(3'h6, p[7:0]);
        wr(3'h7, {6'h00, p[9:8]});
    endtask
    task automatic run(input logic [2:0] ck);
        wr(3'h0, {1'b0, ck, 4'h8});
        // Two edges: the run rising edge and one settled cycle, before any match.
        repeat (2) @(posedge mclk);
        #1;
        ba = n_a;
        bp = n_p;
        bt = n_tog;
    endtask
    task automatic wait_a(input int lim);
        repeat (lim) begin
            @(posedge mclk);
            #1;
            if (a_flag === 1'b1) begin
                return;
            end
        end
        n_fail++;
        $display("ERROR compare flag expected 1 seen 0");
        print_verdict();
    endtask
    ////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        rst_n = 1'b0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        repeat (2) @(posedge mclk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd(i[2:0], v);
            chk("reset value", 16'h0, {8'h00, v});
        end
        wr(3'h2, 8'hff);
        wr(3'h3, 8'hff);
        wr(3'h5, 8'hff);
        wr(3'h4, 8'ha5);
        wr(3'h0, 8'h87);
        rd(3'h2, v);
        chk("count low", 16'h0, {8'h00, v});
        rd(3'h3, v);
        chk("count high", 16'h0, {8'h00, v});
        rd(3'h5, v);
        chk("compare a high", 16'h3, {8'h00, v});
        rd(3'h4, v);
        chk("compare a low", 16'ha5, {8'h00, v});
        rd(3'h0, v);
        chk("control zero", 16'h80, {8'h00, v});
        // Compare mode, clear on A, toggle output.
        cfg(8'h31, 10'h2, 10'h0);
        run(3'h1);
        wait_a(20);
        chk("pin first toggle", 16'h1, {15'h0, pin});
        wait_a(20);
        chk("pin second toggle", 16'h0, {15'h0, pin});
        repeat (2) @(posedge mclk);
        chk("a spacing", 16'd3, a_gap[15:0]);
        chk("no p flag", 16'd0, 16'(n_p - bp));
        // Compare mode, clear on P, both flags.
        cfg(8'h30, 10'h2, 10'h9);
        run(3'h1);
        repeat (40) @(posedge mclk);
        #1;
        chk("p spacing", 16'd10, p_gap[15:0]);
        chk("a spacing", 16'd10, a_gap[15:0]);
        chk("p seen", 16'd1, {15'h0, (n_p - bp) > 0});
        chk("toggles", 16'(n_a - ba), 16'(n_tog - bt));
        wr(3'h0, 8'h98);
        rd(3'h2, v);
        repeat (3) @(posedge mclk);
        rd(3'h2, w);
        chk("paused count", {8'h00, v}, {8'h00, w});
        wr(3'h0, 8'h10);
        rd(3'h2, v);
        repeat (3) @(posedge mclk);
        rd(3'h2, w);
        chk("stopped count", {8'h00, v}, {8'h00, w});
        wr(3'h0, 8'h18);
        rd(3'h2, v);
        chk("restart count", 16'h0, {8'h00, v});
        // Initial level, equal request level and polarity.
        cfg(8'h29, 10'h2, 10'h0);
        run(3'h1);
        chk("initial level", 16'h1, {15'h0, pin});
        repeat (20) @(posedge mclk);
        #1;
        chk("no change", 16'd0, 16'(n_tog - bt));
        chk("a seen", 16'd1, {15'h0, (n_a - ba) > 0});
        cfg(8'h2d, 10'h2, 10'h0);
        run(3'h1);
        chk("inverted level", 16'h0, {15'h0, pin});
        // Initial high, forced low on the first A match.
        cfg(8'h19, 10'h2, 10'h0);
        run(3'h1);
        wait_a(20);
        chk("pin forced low", 16'h0, {15'h0, pin});
        // Zero compare A: overflow only.
        cfg(8'h00, 10'h0, 10'h0);
        run(3'h1);
        repeat (1100) @(posedge mclk);
        #1;
        chk("a flags", 16'd0, 16'(n_a - ba));
        chk("overflow flags", 16'd1, 16'(n_p - bp));
        // Clock sources in timer mode: internal sources clear on A at 3, pin edges count five pulses with clear on P.
        cfg(8'hc1, 10'h3, 10'h0);
        for (int c = 0; c < 6; c++) begin
            wr(3'h0, 8'h00);
            run(c[2:0]);
            chk("timer enable", 16'h0, {15'h0, en});
            wait_a(600);
            wait_a(600);
            repeat (2) @(posedge mclk);
            chk("tick spacing", 16'(4 * fac[c]), a_gap[15:0]);
        end
        cfg(8'hc0, 10'h0, 10'h0);
        for (int c = 6; c < 8; c++) begin
            wr(3'h0, 8'h00);
            run(c[2:0]);
            pins.ext_pulses(5);
            rd(3'h2, v);
            chk("pin clock count", 16'd5, {8'h00, v});
        end
        // Capture edge kinds, then capture from the clock pin.
        for (int k = 0; k < 4; k++) begin
            cfg({2'b01, k[1:0], 4'h0}, 10'h0, 10'h0);
            run(3'h1);
            pins.cap_set(1'b1);
            pins.cap_set(1'b0);
            chk("captures", 16'(capn[k]), 16'(n_a - ba));
        end
        cfg(8'h42, 10'h0, 10'h0);
        run(3'h1);
        pins.cap_set(1'b1);
        pins.cap_set(1'b0);
        chk("capture pin ignored", 16'd0, 16'(n_a - ba));
        pins.ext_pulses(1);
        chk("clock pin capture", 16'd1, 16'(n_a - ba));
        // Forced levels, PWM period and single pulse.
        cfg(8'h98, 10'h2, 10'h4);
        run(3'h1);
        chk("forced active", 16'h1, {15'h0, pin});
        chk("pin enable", 16'h1, {15'h0, en});
        cfg(8'h88, 10'h2, 10'h4);
        run(3'h1);
        chk("forced inactive", 16'h0, {15'h0, pin});
        cfg(8'ha9, 10'h2, 10'h4);
        run(3'h1);
        repeat (30) @(posedge mclk);
        chk("pwm period", 16'd5, p_gap[15:0]);
        cfg(8'hb8, 10'h5, 10'h0);
        run(3'h1);
        chk("pulse lead", 16'h1, {15'h0, pin});
        repeat (20) @(posedge mclk);
        rd(3'h0, v);
        chk("run cleared", 16'h10, {8'h00, v});
        chk("pulse trail", 16'h0, {15'h0, pin});
        pins.ext_pulses(1);
        repeat (20) @(posedge mclk);
        #1;
        chk("pin trigger", 16'd2, 16'(n_a - ba));
        print_verdict();
    end
endmodule
`default_nettype wire
